// file: rtl/bic_defines.svh
// constants of the banked interrupt controller: offsets, fields, levels, timing
// assumes inclusion by bic_pkg.sv and the design modules, by bare name
`ifndef BIC_DEFINES_SVH
`define BIC_DEFINES_SVH

// ****************************************************************
// register map: byte offsets inside one bank window of 64 bytes
// ****************************************************************
`define BIC_OFF_IW1       6'h00
`define BIC_OFF_IW2       6'h04
`define BIC_OFF_IW3       6'h08
`define BIC_OFF_MASK      6'h0C
`define BIC_OFF_CMD       6'h10
`define BIC_OFF_STATUS    6'h14
`define BIC_OFF_VWR_VEC   6'h00
`define BIC_VEC_BIT       5
`define BIC_BANK_A        2'h0
`define BIC_BANK_B        2'h1
`define BIC_BANK_C        2'h2
`define BIC_BANK_EXTRA    2'h3

// ****************************************************************
// fields
// ****************************************************************
`define BIC_IW1_AUTO      1
`define BIC_IW1_LEVEL     3
`define BIC_CMD_DONE      5
`define BIC_CMD_SPEC      6

// ****************************************************************
// levels and fixed values
// ****************************************************************
`define BIC_LVL_CHAIN     3'h1
`define BIC_LVL_CASC_A    3'h2
`define BIC_LVL_COUNT     3'h4
`define BIC_LVL_CASC_B    3'h5
`define BIC_LVL_DEFAULT   3'h7
`define BIC_NO_SLAVE      8'h00
`define BIC_BYTE_RESET    8'h00
`define BIC_WORD_ZERO     32'h0000_0000
`define BIC_PINS_IDLE     28'hFFF_FFFF

// ****************************************************************
// timing
// ****************************************************************
`define BIC_CLK_MHZ       50
`define BIC_ACK_WAIT_NS   100
`define BIC_ACK_WAIT_CYC  4'((`BIC_ACK_WAIT_NS * `BIC_CLK_MHZ + 999) / 1000)

`endif

// file: rtl/bic_pkg.sv
// types shared by the banked interrupt controller modules
// assumes bic_defines.svh is on the include path
`include "bic_defines.svh"

package bic_pkg;

  // host cycle status pins, all sampled through the pin synchroniser
  typedef struct packed {
    logic ads_n;
    logic mio;
    logic dc;
    logic wr;
  } bic_bus_t;

  // result of resolving an acknowledge
  typedef struct packed {
    logic [7:0] vec;
    logic       slave;
    logic [2:0] banks;
    logic [2:0] lvl_a;
    logic [2:0] lvl_b;
    logic [2:0] lvl_c;
  } bic_ack_t;

  typedef enum logic [1:0] {
    bic_st_idle = 2'b00,
    bic_st_ack1 = 2'b01,
    bic_st_gap  = 2'b10,
    bic_st_ack2 = 2'b11
  } bic_state_t;

endpackage

// file: rtl/bic_bank.sv
// one priority bank: request latch, in-service bits, fully nested resolver
// assumes requests active high and on clk_in; take and done are one-cycle pulses
`timescale 1ns/1ns
`include "bic_defines.svh"

module bic_bank (
  input  wire logic       clk_in,        // system clock
  input  wire logic       resetn_in,     // async reset, active low
  input  wire logic [7:0] req_in,        // level requests, active high
  input  wire logic       level_mode_in, // 1: level, 0: edge triggered
  input  wire logic [7:0] mask_in,       // 1 disables a level
  input  wire logic       take_in,       // acknowledge of take_level_in
  input  wire logic [2:0] take_level_in, // level being acknowledged
  input  wire logic       done_any_in,   // non-specific service done
  input  wire logic       done_one_in,   // specific service done
  input  wire logic [2:0] done_level_in, // level for specific done
  output logic            int_out,       // any allowed request
  output logic [2:0]      top_level_out, // highest allowed level
  output logic [7:0]      pending_out,   // request bits
  output logic [7:0]      in_service_out // in-service bits
);
  import bic_pkg::*;

  logic [7:0] pending_request_bits_q;
  logic [7:0] in_service_bits_q;
  logic [7:0] req_prev_q;
  logic [7:0] allowed;
  logic [7:0] take_hot;
  logic [7:0] done_hot;
  logic [7:0] isr_low;

  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // level 0 highest; in service blocks same and lower levels
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_lvl
      assign allowed[g] = pending_request_bits_q[g] & ~mask_in[g]
                          & ~(|in_service_bits_q[g:0]);
    end
  endgenerate

  assign take_hot = take_in ? (8'h01 << take_level_in) : 8'h00;
  assign isr_low  = in_service_bits_q & (~in_service_bits_q + 8'h01);
  assign done_hot = (done_any_in ? isr_low : 8'h00)
                  | (done_one_in ? (8'h01 << done_level_in) : 8'h00);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req_prev_q <= `BIC_BYTE_RESET;
    end else begin
      req_prev_q <= req_in;
    end
  end

  // edge mode latches a rise until acknowledged; a new rise beats the clear
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pending_request_bits_q <= `BIC_BYTE_RESET;
    end else if (level_mode_in) begin
      pending_request_bits_q <= req_in;
    end else begin
      pending_request_bits_q <= (req_in & ~req_prev_q)
                              | (pending_request_bits_q & ~take_hot);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      in_service_bits_q <= `BIC_BYTE_RESET;
    end else begin
      in_service_bits_q <= take_hot | (in_service_bits_q & ~done_hot);
    end
  end

  assign int_out        = |allowed;
  assign top_level_out  = first_set(allowed);
  assign pending_out    = pending_request_bits_q;
  assign in_service_out = in_service_bits_q;

endmodule

// file: rtl/bic_controller.sv
// banked interrupt controller top: three chained banks, acknowledge sequencer,
// Avalon-MM register slave with one wait state per access
// assumes host status pins and request pins are asynchronous to clk_in
`timescale 1ns/1ns
`include "bic_defines.svh"

module bic_controller (
  input  wire logic             clk_in,                     // 50 MHz system clock
  input  wire logic             resetn_in,                  // async reset, active low
  input  wire logic [23:0]      irq_n_in,                   // request pins c,b,a, low active
  input  wire bic_pkg::bic_bus_t bus_status_in,             // host cycle status pins
  input  wire logic             dma_chain_request_in,       // base register not loaded
  input  wire logic             dma_count_done_request_in,  // pulse, sw request cleared
  input  wire logic [7:0]       avs_address_in,             // byte address
  input  wire logic             avs_read_in,                // read request
  input  wire logic             avs_write_in,               // write request
  input  wire logic [31:0]      avs_writedata_in,           // write data
  input  wire logic [3:0]       avs_byteenable_in,          // byte lanes
  output logic [31:0]           avs_readdata_out,           // read data
  output logic                  avs_waitrequest_out,        // stall, high by default
  output logic                  host_irq_input_out,         // interrupt to host
  output logic [7:0]            ack_data_out,               // acknowledge data
  output logic                  ack_data_oe_out,            // drive enable for ack data
  output logic                  ack_ready_out               // end of ack wait states
);
  import bic_pkg::*;

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  logic [27:0] sync1_q;
  logic [27:0] sync2_q;
  logic [27:0] sync3_q;
  logic [27:0] pins_q;
  bic_bus_t    bus_s;
  logic [23:0] irq_s;
  logic        ads_prev_q;
  logic        ack_start;

  // a bit changes only once the second and third stages agree
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_q <= `BIC_PINS_IDLE;
      sync2_q <= `BIC_PINS_IDLE;
      sync3_q <= `BIC_PINS_IDLE;
      pins_q  <= `BIC_PINS_IDLE;
    end else begin
      sync1_q <= {bus_status_in, irq_n_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pins_q  <= (sync2_q & sync3_q) | (pins_q & (sync2_q ^ sync3_q));
    end
  end

  assign bus_s = pins_q[27:24];
  assign irq_s = ~pins_q[23:0];

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ads_prev_q <= 1'b1;
    end else begin
      ads_prev_q <= bus_s.ads_n;
    end
  end

  assign ack_start = ads_prev_q & ~bus_s.ads_n
                   & ~bus_s.mio & ~bus_s.dc & ~bus_s.wr;

  // ****************************************************************
  // register slave
  // ****************************************************************
  logic [7:0]  iw1_q [3];
  logic [7:0]  iw2_q [3];
  logic [7:0]  iw3_q [3];
  logic [7:0]  mask_q [3];
  logic [7:0]  vec_q [24];
  logic [7:0]  vwr_vec_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        wr_go;
  logic        rd_go;
  logic [1:0]  sel_bank;
  logic [5:0]  sel_off;
  logic        sel_vec;
  logic        cmd_wr [3];

  assign sel_bank = avs_address_in[7:6];
  assign sel_off  = avs_address_in[5:0];
  assign sel_vec  = sel_off[`BIC_VEC_BIT] && (sel_off[1:0] == 2'h0)
                    && (sel_bank != `BIC_BANK_EXTRA);
  assign wr_go    = avs_write_in & ~wait_q & avs_byteenable_in[0];
  assign rd_go    = avs_read_in & ~wait_q;

  // one wait state: the answer stands at the edge where waitrequest is low
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_q  <= 1'b1;
      rdata_q <= `BIC_WORD_ZERO;
    end else begin
      wait_q  <= ~((avs_read_in | avs_write_in) & wait_q);
      if (avs_read_in & wait_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int b = 0; b < 3; b++) begin
        iw1_q[b]  <= `BIC_BYTE_RESET;
        iw2_q[b]  <= `BIC_BYTE_RESET;
        iw3_q[b]  <= `BIC_BYTE_RESET;
        mask_q[b] <= `BIC_BYTE_RESET;
      end
      vwr_vec_q <= `BIC_BYTE_RESET;
    end else if (wr_go) begin
      for (int b = 0; b < 3; b++) begin
        if (sel_bank == 2'(b)) begin
          case (sel_off)
            `BIC_OFF_IW1:  iw1_q[b]  <= avs_writedata_in[7:0];
            `BIC_OFF_IW2:  iw2_q[b]  <= avs_writedata_in[7:0];
            `BIC_OFF_IW3:  iw3_q[b]  <= avs_writedata_in[7:0];
            `BIC_OFF_MASK: mask_q[b] <= avs_writedata_in[7:0];
            default: begin
            end
          endcase
        end
      end
      if (sel_bank == `BIC_BANK_EXTRA && sel_off == `BIC_OFF_VWR_VEC) begin
        vwr_vec_q <= avs_writedata_in[7:0];
      end
    end
  end

  // vector registers are not reset: software programs them before use
  always_ff @(posedge clk_in) begin
    if (wr_go && sel_vec) begin
      vec_q[{sel_bank, sel_off[4:2]}] <= avs_writedata_in[7:0];
    end
  end

  // ****************************************************************
  // banks
  // ****************************************************************
  logic [7:0] bank_req [3];
  logic       bank_int [3];
  logic [2:0] top_lvl [3];
  logic [7:0] bank_irr [3];
  logic [7:0] bank_isr [3];
  logic       take [3];
  logic [2:0] take_lvl [3];
  logic       done_any [3];
  logic       done_one [3];
  logic       vwr_q;
  logic       count_done_q;
  logic       auto_go;
  logic       ack_take;
  bic_ack_t   ack_d;
  bic_ack_t   ack_q;

  always_comb begin
    bank_req[2] = irq_s[23:16];
    bank_req[1] = irq_s[15:8];
    bank_req[1][`BIC_LVL_CASC_B] = bank_int[2];
    bank_req[0] = irq_s[7:0];
    bank_req[0][`BIC_LVL_CHAIN]  = dma_chain_request_in;
    bank_req[0][`BIC_LVL_COUNT]  = count_done_q;
    bank_req[0][`BIC_LVL_CASC_A] = bank_int[1] | vwr_q;
  end

  genvar gb;
  generate
    for (gb = 0; gb < 3; gb++) begin : g_bank
      assign cmd_wr[gb]   = wr_go && sel_bank == 2'(gb) && sel_off == `BIC_OFF_CMD
                            && avs_writedata_in[`BIC_CMD_DONE];
      assign done_one[gb] = cmd_wr[gb] & avs_writedata_in[`BIC_CMD_SPEC];
      assign done_any[gb] = (cmd_wr[gb] & ~avs_writedata_in[`BIC_CMD_SPEC])
                          | (auto_go & ack_q.banks[gb] & iw1_q[gb][`BIC_IW1_AUTO]);
      assign take[gb]     = ack_take & ack_d.banks[gb];

      bic_bank u_bank (
        .clk_in         (clk_in),
        .resetn_in      (resetn_in),
        .req_in         (bank_req[gb]),
        .level_mode_in  (iw1_q[gb][`BIC_IW1_LEVEL]),
        .mask_in        (mask_q[gb]),
        .take_in        (take[gb]),
        .take_level_in  (take_lvl[gb]),
        .done_any_in    (done_any[gb]),
        .done_one_in    (done_one[gb]),
        .done_level_in  (avs_writedata_in[2:0]),
        .int_out        (bank_int[gb]),
        .top_level_out  (top_lvl[gb]),
        .pending_out    (bank_irr[gb]),
        .in_service_out (bank_isr[gb])
      );
    end
  endgenerate

  assign take_lvl[0] = ack_d.lvl_a;
  assign take_lvl[1] = ack_d.lvl_b;
  assign take_lvl[2] = ack_d.lvl_c;

  // a fresh event wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vwr_q <= 1'b0;
    end else begin
      vwr_q <= (wr_go && sel_off == `BIC_OFF_IW2 && sel_bank != `BIC_BANK_EXTRA)
             | (vwr_q & ~(rd_go && sel_off == `BIC_OFF_IW2
                          && sel_bank != `BIC_BANK_EXTRA));
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_done_q <= 1'b0;
    end else begin
      count_done_q <= dma_count_done_request_in
                    | (count_done_q & ~(take[0] && ack_d.lvl_a == `BIC_LVL_COUNT));
    end
  end

  // ****************************************************************
  // acknowledge resolution: walk down the cascade from the top bank
  // ****************************************************************
  always_comb begin
    ack_d     = '0;
    ack_d.vec = vec_q[{`BIC_BANK_A, `BIC_LVL_DEFAULT}];
    if (bank_int[0]) begin
      ack_d.banks[0] = 1'b1;
      ack_d.lvl_a    = top_lvl[0];
      if (top_lvl[0] == `BIC_LVL_CASC_A && vwr_q) begin
        ack_d.vec = vwr_vec_q;
      end else if (top_lvl[0] == `BIC_LVL_CASC_A) begin
        if (bank_int[1]) begin
          ack_d.banks[1] = 1'b1;
          ack_d.lvl_b    = top_lvl[1];
          if (top_lvl[1] == `BIC_LVL_CASC_B) begin
            if (bank_int[2]) begin
              ack_d.banks[2] = 1'b1;
              ack_d.lvl_c    = top_lvl[2];
              ack_d.vec      = vec_q[{`BIC_BANK_C, top_lvl[2]}];
              ack_d.slave    = iw3_q[2][top_lvl[2]];
            end
          end else begin
            ack_d.vec   = vec_q[{`BIC_BANK_B, top_lvl[1]}];
            ack_d.slave = iw3_q[1][top_lvl[1]];
          end
        end
      end else begin
        ack_d.vec   = vec_q[{`BIC_BANK_A, top_lvl[0]}];
        ack_d.slave = iw3_q[0][top_lvl[0]];
      end
    end
  end

  // ****************************************************************
  // acknowledge sequencer
  // ****************************************************************
  bic_state_t state_q;
  logic [3:0] wait_cnt_q;
  logic [7:0] data_q;
  logic       oe_q;
  logic       ready_q;
  logic       irq_q;

  assign ack_take = (state_q == bic_st_idle) & ack_start;
  assign auto_go  = (state_q == bic_st_ack2) && (wait_cnt_q == 4'h0);

  // the gap between the two acknowledges is left to the host
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q    <= bic_st_idle;
      wait_cnt_q <= 4'h0;
      data_q     <= `BIC_BYTE_RESET;
      oe_q       <= 1'b0;
      ready_q    <= 1'b0;
      ack_q      <= '0;
    end else begin
      case (state_q)
        bic_st_idle: begin
          ready_q <= 1'b0;
          oe_q    <= 1'b0;
          if (ack_start) begin
            state_q    <= bic_st_ack1;
            wait_cnt_q <= `BIC_ACK_WAIT_CYC;
            oe_q       <= 1'b1;
            data_q     <= ack_d.slave ? ack_d.vec : `BIC_NO_SLAVE;
            ack_q      <= ack_d;
          end
        end
        bic_st_ack1, bic_st_ack2: begin
          if (wait_cnt_q == 4'h0) begin
            ready_q <= 1'b1;
            state_q <= (state_q == bic_st_ack1) ? bic_st_gap : bic_st_idle;
          end else begin
            wait_cnt_q <= wait_cnt_q - 4'h1;
          end
        end
        bic_st_gap: begin
          ready_q <= 1'b0;
          oe_q    <= 1'b0;
          if (ack_start) begin
            state_q    <= bic_st_ack2;
            wait_cnt_q <= `BIC_ACK_WAIT_CYC;
            oe_q       <= ~ack_q.slave;
            data_q     <= ack_q.vec;
          end
        end
        default: begin
          state_q <= bic_st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= bank_int[0];
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    rdata_d = `BIC_WORD_ZERO;
    if (sel_vec) begin
      rdata_d[7:0] = vec_q[{sel_bank, sel_off[4:2]}];
    end else if (sel_bank == `BIC_BANK_EXTRA) begin
      if (sel_off == `BIC_OFF_VWR_VEC) begin
        rdata_d[7:0] = vwr_vec_q;
      end
    end else begin
      case (sel_off)
        `BIC_OFF_IW1:    rdata_d[7:0] = iw1_q[sel_bank];
        `BIC_OFF_IW2:    rdata_d[7:0] = iw2_q[sel_bank];
        `BIC_OFF_IW3:    rdata_d[7:0] = iw3_q[sel_bank];
        `BIC_OFF_MASK:   rdata_d[7:0] = mask_q[sel_bank];
        `BIC_OFF_STATUS: rdata_d[16:0] = {bank_int[sel_bank], bank_isr[sel_bank],
                                          bank_irr[sel_bank]};
        default:         rdata_d = `BIC_WORD_ZERO;
      endcase
    end
  end

  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign host_irq_input_out  = irq_q;
  assign ack_data_out        = data_q;
  assign ack_data_oe_out     = oe_q;
  assign ack_ready_out       = ready_q;

endmodule

// file: testbench/bic_host_model.sv
// host side of the acknowledge link: one go pulse makes one acknowledge pair
// assumes go_in lasts one cycle and the controller ends each cycle with ready_in
`timescale 1ns/1ns
module bic_host_model (
  input  wire logic        clk_in,      // system clock
  input  wire logic        go_in,       // start a pair
  input  wire logic        slow_in,     // stretch the idle gap
  input  wire logic [7:0]  ack_data_in, // controller data
  input  wire logic        ack_oe_in,   // controller drives data
  input  wire logic        ready_in,    // end of wait states
  output bic_pkg::bic_bus_t status_out, // cycle status pins
  output logic [15:0]      data_out,    // first and second byte
  output logic             oe_out,      // enable seen in second cycle
  output int               done_out     // pairs completed
);
  import bic_pkg::*;
  initial begin
    status_out = 4'hF;
    data_out = 16'h0000;
    oe_out = 1'b0;
    done_out = 0;
  end
  always @(posedge clk_in) if (go_in) begin
    for (int k = 0; k < 2; k++) begin
      status_out <= 4'h0;
      do @(posedge clk_in); while (ready_in !== 1'b1);
      data_out <= {data_out[7:0], ack_data_in};
      oe_out <= ack_oe_in;
      status_out <= 4'hF;
      repeat (slow_in ? 12 : 4) @(posedge clk_in);
    end
    done_out <= done_out + 1;
  end
endmodule

// file: testbench/bic_controller_properties.sv
// timing checks on the controller ports
// assumes one clock and the one-wait-state register slave
`timescale 1ns/1ns
module bic_controller_properties (
  input wire logic       clk_in,              // clock
  input wire logic       resetn_in,           // reset, low
  input wire logic       avs_read_in,         // read
  input wire logic       avs_write_in,        // write
  input wire logic       avs_waitrequest_out, // stall
  input wire logic       host_irq_input_out,  // interrupt
  input wire logic [7:0] ack_data_out,        // ack data
  input wire logic       ack_data_oe_out,     // ack enable
  input wire logic       ack_ready_out        // ack end
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("no bus answer");
  a_wait_brief: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer too long");
  a_wait_idle: assert property (!avs_read_in && !avs_write_in && avs_waitrequest_out
    |=> avs_waitrequest_out) else $error("answer without request");
  a_ready_pulse: assert property (ack_ready_out |=> !ack_ready_out)
    else $error("ready too long");
  a_ready_delay: assert property ($rose(ack_data_oe_out) |-> ##6 ack_ready_out)
    else $error("wait states wrong");
  a_oe_release: assert property (ack_ready_out |=> !ack_data_oe_out)
    else $error("data left driven");
  a_data_hold: assert property ($rose(ack_data_oe_out) |=> $stable(ack_data_out)[*6])
    else $error("ack data moved");
  a_reset_quiet: assert property ($rose(resetn_in) |-> !host_irq_input_out
    && !ack_data_oe_out && avs_waitrequest_out) else $error("not quiet after reset");
endmodule
bind bic_controller bic_controller_properties i_chk (.clk_in, .resetn_in, .avs_read_in,
  .avs_write_in, .avs_waitrequest_out, .host_irq_input_out, .ack_data_out,
  .ack_data_oe_out, .ack_ready_out);

// file: testbench/bic_controller_tb_top.sv
// bench of the interrupt controller: table of requests, then hand cases
// assumes the host model answers acknowledges and the checker is bound
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %0t %h %h", $time, g, e); end end
module bic_controller_tb_top;
  import bic_pkg::*;
  typedef struct packed {
    logic [25:0] src;
    logic [7:0]  e1;
    logic [7:0]  e2;
    logic        oe;
  } bic_row_t;
  bic_row_t rows[5] = '{'{26'h0FF_FFFE, 8'h00, 8'h40, 1'b1}, '{26'h0FF_FFF7, 8'h43, 8'h00, 1'b0},
    '{26'h1FF_FFBF, 8'h00, 8'h41, 1'b1}, '{26'h2FF_FFFF, 8'h00, 8'h44, 1'b1},
    '{26'h0BF_FFDF, 8'h00, 8'h66, 1'b1}};
  logic        clk_in = 1'b0, resetn_in = 1'b0, rd = 1'b0, wr = 1'b0, go = 1'b0, slow = 1'b0;
  logic        wt, irq, aoe, ardy, hoe;
  logic [25:0] src = 26'h0FF_FFFF;
  logic [7:0]  adr = 8'h00, wd = 8'h00, ad;
  logic [15:0] hd;
  logic [31:0] rdata, q;
  bic_bus_t    st;
  int          checks = 0, n_errors = 0, t, done;
  always #10 clk_in = ~clk_in;
  bic_controller i_dut (.clk_in, .resetn_in, .irq_n_in(src[23:0]), .bus_status_in(st),
    .dma_chain_request_in(src[24]), .dma_count_done_request_in(src[25]), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(32'(wd)), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wt), .host_irq_input_out(irq),
    .ack_data_out(ad), .ack_data_oe_out(aoe), .ack_ready_out(ardy));
  bic_host_model i_host (.clk_in, .go_in(go), .slow_in(slow), .ack_data_in(ad), .ack_oe_in(aoe),
    .ready_in(ardy), .status_out(st), .data_out(hd), .oe_out(hoe), .done_out(done));
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk_in); while (wt !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic ack();
    int n;
    n = done;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    while (done == n) @(posedge clk_in);
  endtask
  task automatic irqis(input logic v);
    t = 0;
    while (irq !== v && ++t < 100) @(posedge clk_in);
    `CHK(irq, v)
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int b = 0; b < 3; b++) begin
      acc(1'b1, 8'(b * 64), 8'h08);
      for (int n = 0; n < 8; n++) begin
        acc(1'b1, 8'(b * 64 + 32 + 4 * n), 8'(64 + 16 * b + n));
      end
    end
    acc(1'b1, 8'h08, 8'h08);
    acc(1'b1, 8'hC0, 8'hA5);
    foreach (rows[i]) begin
      src <= rows[i].src;
      @(posedge clk_in);
      src[25] <= 1'b0;
      irqis(1'b1);
      ack();
      src <= 26'h0FF_FFFF;
      `CHK(hd[15:8], rows[i].e1)
      `CHK(hoe, rows[i].oe)
      if (rows[i].oe) `CHK(hd[7:0], rows[i].e2)
      for (int b = 0; b < 3; b++) acc(1'b1, 8'(b * 64 + 16), 8'h20);
      $display("row %0d done", i);
    end
    acc(1'b1, 8'h0C, 8'h20);
    src <= 26'h0FF_FFDF;
    repeat (20) @(posedge clk_in);
    `CHK(irq, 1'b0)
    acc(1'b1, 8'h0C, 8'h00);
    irqis(1'b1);
    ack();
    `CHK(hd[7:0], 8'h45)
    src <= 26'h0FF_FFBF;
    // a lower level stays blocked while level 5 is in service; the pins pass it to the output in six edges
    repeat (10) @(posedge clk_in);
    `CHK(irq, 1'b0)
    src <= 26'h0FF_FFBE;
    irqis(1'b1);
    ack();
    src <= 26'h0FF_FFFF;
    `CHK(hd[7:0], 8'h40)
    acc(1'b1, 8'h10, 8'h65);
    acc(1'b0, 8'h14, 8'h00);
    `CHK(q[15:8], 8'h01)
    acc(1'b1, 8'h10, 8'h20);
    acc(1'b0, 8'h14, 8'h00);
    `CHK(q[15:8], 8'h00)
    $display("nesting done");
    src <= 26'h0FF_FEFF;
    acc(1'b1, 8'h04, 8'h00);
    irqis(1'b1);
    ack();
    `CHK(hd[7:0], 8'hA5)
    src <= 26'h0FF_FFFF;
    acc(1'b0, 8'h04, 8'h00);
    acc(1'b1, 8'h10, 8'h20);
    acc(1'b1, 8'h44, 8'h00);
    acc(1'b0, 8'h44, 8'h00);
    repeat (4) @(posedge clk_in);
    `CHK(irq, 1'b0)
    slow <= 1'b1;
    ack();
    `CHK(hd[7:0], 8'h47)
    $display("vector write done");
    acc(1'b1, 8'h00, 8'h0A);
    src <= 26'h0FF_FFFE;
    irqis(1'b1);
    ack();
    acc(1'b0, 8'h14, 8'h00);
    `CHK(q[15:8], 8'h00)
    irqis(1'b1);
    $display("auto done test done");
    resetn_in <= 1'b0;
    @(posedge clk_in);
    `CHK(irq, 1'b0)
    resetn_in <= 1'b1;
    @(posedge clk_in);
    `CHK(wt, 1'b1)
    `CHK(irq, 1'b0)
    irqis(1'b1);
    $display("reset test done");
    results();
  end
endmodule
